// ### dprc_pkg.sv
// Package of constants for the dual-port memory port controller
package dprc_pkg;
    localparam int          ADDR_W        = 14;
    localparam int          DATA_W        = 18;
    localparam logic [13:0] MBOX_RIGHT    = 14'h3FFF;
    localparam logic [13:0] MBOX_LEFT     = 14'h3FFE;
    localparam int          TOKEN_COUNT   = 8;
    localparam int          TOKEN_ADDR_W  = 3;
    localparam int          CLK_PERIOD_NS = 100;
    // Least setup of data before strobe release, in ns
    localparam int          T_SETUP_NS    = 15;
    localparam int          SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least access time before sampling read data, in ns
    localparam int          T_ACCESS_NS   = 20;
    localparam int          ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Port-to-port flowthrough wait before reading a freshly written word, in ns
    localparam int          T_FLOW_NS     = 30;
    localparam int          FLOW_CYC      = (T_FLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Semaphore deselect time between write and read-back, in ns
    localparam int          T_TOKEN_NS    = 10;
    localparam int          TOKEN_CYC     = (T_TOKEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
endpackage : dprc_pkg

// ### dprc_wait_if.sv
`timescale 1ns/1ps
// Interface between the sequencer and its wait counter
interface dprc_wait_if;
    logic       load;
    logic [3:0] count;
    logic       done;
    modport seq (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : dprc_wait_if

// ### dprc_wait.sv
`timescale 1ns/1ps
// Down counter that times the strobe phases of a port cycle
module dprc_wait (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    dprc_wait_if.tmr    w
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // Load, then count down to zero
    always_comb begin
        if (w.load) begin
            cnt_nxt = w.count;
        end else if (cnt_r != dprc_pkg::CNT_ZERO) begin
            cnt_nxt = cnt_r - 4'h1;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Done looks at the count only; a load decided from done must not feed back into it
    assign w.done = (cnt_r == dprc_pkg::CNT_ZERO);
endmodule : dprc_wait

// ### dprc_port_ctrl.sv
`timescale 1ns/1ps
// Controller that drives one port of the shared dual-port memory
// Function
// R1: Each port accesses every word independently
// R2: Memory holds 16K words, 16 or 18 bits
// R3: Byte selects gate upper and lower lanes
// R4: Master drives busy, slave takes busy
// R5: Busy asserted on same-word contention
// R6: Mailbox alert flag on each port
// R7: Eight shared semaphore latches
// R8: Each latch owned by at most one port
// R9: Port powers down when deselected
// R10: Write ended by write line or select
// R11: Data stable before write strobe rising edge
// R12: Wait flowthrough delay before reading new data
// R13: Read data driven only under output enable
// R14: Devices combine as master plus slaves
// R15: Top words are right and left mailboxes
// R16: Owner read of mailbox clears alert
// R17: Semaphore: token select, select high, bit0
// R18: 14-bit word address, bus released otherwise
// R19: Only contention winner's write completes
module dprc_port_ctrl #(
    parameter int DATA_W = dprc_pkg::DATA_W
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // User request side
    input  wire logic                       req_i,
    input  wire logic                       req_write_i,
    input  wire logic                       req_token_i,
    input  wire logic                       req_end_by_sel_i,
    input  wire logic                       req_after_write_i,
    input  wire logic [dprc_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0]          req_wdata_i,
    input  wire logic [1:0]                 req_lanes_i,
    output logic                            ack_o,
    output logic                            retry_o,
    output logic [DATA_W-1:0]               rdata_o,
    output logic                            alert_o,
    // Memory port pins
    output logic                            port_sel_n_o,
    output logic                            write_not_read_o,
    output logic                            out_en_n_o,
    output logic                            token_latch_select_n_o,
    output logic                            high_byte_select_n_o,
    output logic                            low_byte_select_n_o,
    output logic [dprc_pkg::ADDR_W-1:0]     addr_o,
    output logic [DATA_W-1:0]               data_o,
    output logic                            data_oe_n_o,
    input  wire logic [DATA_W-1:0]          data_i,
    input  wire logic                       busy_n_i,
    input  wire logic                       alert_n_i
);
    // Elaboration guard: only the two documented word widths split into lanes
    if (DATA_W != 16 && DATA_W != 18) begin : g_width_chk
        $error("DATA_W must be 16 or 18"); // R2
    end

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_STRB  = 6'h04,
        ST_END   = 6'h08,
        ST_READ  = 6'h10,
        ST_GAP   = 6'h20
    } dprc_state_t;

    dprc_state_t                 st_r, st_nxt;
    logic                        sel_n_r, sel_n_nxt;
    logic                        wnr_r, wnr_nxt;
    logic                        oe_n_r, oe_n_nxt;
    logic                        tok_n_r, tok_n_nxt;
    logic                        hb_n_r, hb_n_nxt;
    logic                        lb_n_r, lb_n_nxt;
    logic [dprc_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0]           dout_r, dout_nxt;
    logic                        doe_n_r, doe_n_nxt;
    logic                        ack_r, ack_nxt;
    logic                        retry_r, retry_nxt;
    logic [DATA_W-1:0]           rdata_r, rdata_nxt;
    logic                        alert_r, alert_nxt;
    logic                        bysel_r, bysel_nxt;
    dprc_wait_if                 wt ();

    dprc_wait u_wait (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .w       (wt)
    );

    // Cycle sequencer; strobes return high between accesses so the port powers down
    always_comb begin
        st_nxt    = st_r;
        sel_n_nxt = sel_n_r;
        wnr_nxt   = wnr_r;
        oe_n_nxt  = oe_n_r;
        tok_n_nxt = tok_n_r;
        hb_n_nxt  = hb_n_r;
        lb_n_nxt  = lb_n_r;
        addr_nxt  = addr_r;
        dout_nxt  = dout_r;
        doe_n_nxt = doe_n_r;
        ack_nxt   = 1'b0;
        retry_nxt = 1'b0;
        rdata_nxt = rdata_r;
        bysel_nxt = bysel_r;
        alert_nxt = !alert_n_i;                       // R6 R15 R16
        wt.load   = 1'b0;
        wt.count  = 4'h0;
        case (st_r)
            ST_IDLE: begin
                if (req_i) begin
                    bysel_nxt = req_end_by_sel_i;
                    addr_nxt  = req_addr_i;             // R18 R1
                    hb_n_nxt  = !req_lanes_i[1];       // R3
                    lb_n_nxt  = !req_lanes_i[0];       // R3
                    // Write line stays high until the setup wait is done
                    wnr_nxt   = 1'b1;                  // R10
                    // Token access keeps the word select high
                    tok_n_nxt = !req_token_i;           // R17
                    if (req_token_i) begin
                        addr_nxt = {{(dprc_pkg::ADDR_W-dprc_pkg::TOKEN_ADDR_W){1'b0}},
                                    req_addr_i[dprc_pkg::TOKEN_ADDR_W-1:0]}; // R17 R7
                        dout_nxt = {{(DATA_W-1){1'b1}}, req_wdata_i[0]};     // R17
                    end else begin
                        dout_nxt = req_wdata_i;
                    end
                    doe_n_nxt = !req_write_i;          // R11
                    st_nxt    = ST_SETUP;
                    wt.load   = 1'b1;
                    // Reading soon after the other side wrote: wait flowthrough
                    wt.count  = req_after_write_i ? 4'(dprc_pkg::FLOW_CYC) : 4'h0; // R12
                end
            end
            ST_SETUP: begin
                if (wt.done) begin
                    sel_n_nxt = tok_n_r ? 1'b0 : 1'b1; // R9 R17
                    if (!doe_n_r) begin
                        // Data already stable; write line falls now
                        wnr_nxt = 1'b0;                 // R10
                        if (bysel_r) begin
                            sel_n_nxt = 1'b1;
                        end
                        st_nxt = ST_STRB;
                    end else begin
                        oe_n_nxt = 1'b0;                // R13
                        st_nxt   = ST_READ;
                    end
                    wt.load  = 1'b1;
                    wt.count = 4'(dprc_pkg::ACCESS_CYC);
                end
            end
            ST_STRB: begin
                if (bysel_r) begin
                    // Select ends the cycle, write line held low
                    sel_n_nxt = tok_n_r ? 1'b0 : 1'b1; // R10
                    wnr_nxt   = 1'b0;
                end else begin
                    wnr_nxt = 1'b0;
                end
                if (wt.done) begin
                    st_nxt = ST_END;
                    wt.load  = 1'b1;
                    wt.count = 4'(dprc_pkg::SETUP_CYC);
                end
            end
            ST_END: begin
                if (wt.done) begin
                    // Rising strobe captures data held since setup
                    if (bysel_r) begin
                        sel_n_nxt = 1'b1;               // R10 R11
                    end else begin
                        wnr_nxt = 1'b1;                 // R10 R11
                    end
                    // Busy means the write lost arbitration
                    retry_nxt = tok_n_r && !busy_n_i;   // R5 R19 R4 R14
                    ack_nxt   = !retry_nxt;
                    st_nxt    = ST_GAP;
                end
            end
            ST_READ: begin
                if (wt.done) begin
                    rdata_nxt = data_i;
                    retry_nxt = tok_n_r && !busy_n_i;   // R5
                    ack_nxt   = !retry_nxt;
                    oe_n_nxt  = 1'b1;                   // R13 R18
                    sel_n_nxt = 1'b1;
                    st_nxt    = ST_GAP;
                end
            end
            ST_GAP: begin
                // Deselect everything; token read-back needs this gap
                sel_n_nxt = 1'b1;                       // R9
                tok_n_nxt = 1'b1;                       // R8
                wnr_nxt   = 1'b1;
                oe_n_nxt  = 1'b1;
                doe_n_nxt = 1'b1;                       // R18
                hb_n_nxt  = 1'b1;
                lb_n_nxt  = 1'b1;
                st_nxt    = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r    <= ST_IDLE;
            sel_n_r <= 1'b1;
            wnr_r   <= 1'b1;
            oe_n_r  <= 1'b1;
            tok_n_r <= 1'b1;
            hb_n_r  <= 1'b1;
            lb_n_r  <= 1'b1;
            addr_r  <= '0;
            dout_r  <= '0;
            doe_n_r <= 1'b1;
            ack_r   <= 1'b0;
            retry_r <= 1'b0;
            rdata_r <= '0;
            alert_r <= 1'b0;
            bysel_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            sel_n_r <= sel_n_nxt;
            wnr_r   <= wnr_nxt;
            oe_n_r  <= oe_n_nxt;
            tok_n_r <= tok_n_nxt;
            hb_n_r  <= hb_n_nxt;
            lb_n_r  <= lb_n_nxt;
            addr_r  <= addr_nxt;
            dout_r  <= dout_nxt;
            doe_n_r <= doe_n_nxt;
            ack_r   <= ack_nxt;
            retry_r <= retry_nxt;
            rdata_r <= rdata_nxt;
            alert_r <= alert_nxt;
            bysel_r <= bysel_nxt;
        end
    end

    assign ack_o                  = ack_r;
    assign retry_o                = retry_r;
    assign rdata_o                = rdata_r;
    assign alert_o                = alert_r;
    assign port_sel_n_o           = sel_n_r;
    assign write_not_read_o       = wnr_r;
    assign out_en_n_o             = oe_n_r;
    assign token_latch_select_n_o = tok_n_r;
    assign high_byte_select_n_o   = hb_n_r;
    assign low_byte_select_n_o    = lb_n_r;
    assign addr_o                 = addr_r;
    assign data_o                 = dout_r;
    assign data_oe_n_o            = doe_n_r;

    // Data must stay stable across the write strobe release
    data_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!wnr_r && !doe_n_r) |=> $stable(dout_r)) // R11
        else $error("write data changed under strobe");
    // Never drive the bus while reading
    bus_conflict_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(oe_n_r == 1'b0 && doe_n_r == 1'b0)) // R13
        else $error("bus driven while output enabled");
    // Token access keeps the word select high
    token_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !tok_n_r |-> sel_n_r) // R17
        else $error("word select low during token access");
    // Gap deselects the port fully
    gap_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r == ST_GAP) |=> (sel_n_r && tok_n_r && oe_n_r && doe_n_r)) // R9
        else $error("port not deselected after cycle");
    // Contended word write reported as retry, not ack
    busy_retry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r == ST_END && wt.done && tok_n_r && !busy_n_i) |=> (retry_r && !ack_r)) // R19
        else $error("lost write not reported");
    // Alert follows the device flag one cycle later
    alert_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (alert_r == !$past(alert_n_i))) // R6
        else $error("alert output wrong");
    // Address upper bits zero during token access
    token_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !tok_n_r |-> (addr_r[dprc_pkg::ADDR_W-1:dprc_pkg::TOKEN_ADDR_W] == '0)) // R17
        else $error("token address too wide");
    // Ack and retry never together
    ack_excl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(ack_r && retry_r)) // R5
        else $error("ack and retry together");
endmodule : dprc_port_ctrl

// ### dprc_dev_model.sv
`timescale 1ns/1ps
// Behavioural model of one port of the shared dual-port memory
module dprc_dev_model #(
    parameter int DW = 18
) (
    input  wire logic          sel_n_i,
    input  wire logic          wnr_i,
    input  wire logic          oe_n_i,
    input  wire logic          tok_n_i,
    input  wire logic          hb_n_i,
    input  wire logic          lb_n_i,
    input  wire logic [13:0]   addr_i,
    input  wire logic [DW-1:0] data_i,
    input  wire logic          data_oe_n_i,
    input  wire logic          busy_force_i,
    input  wire logic          peer_post_i,
    input  wire logic [7:0]    peer_hold_i,
    output logic [DW-1:0]      data_o,
    output logic               busy_n_o,
    output logic               alert_n_o,
    output logic               peer_flag_o,
    output int                 clash_o
);
    logic [DW-1:0] mem [0:16383];
    logic [7:0]    own_r   = 8'h00;
    logic          alert_r = 1'b0;
    logic [DW-1:0] rd_v;
    logic          drv;
    initial peer_flag_o = 1'b0;
    initial clash_o = 0;
    // Busy shows only while this port is selected
    assign busy_n_o  = ~(busy_force_i & ~sel_n_i);
    assign alert_n_o = ~alert_r;
    // Losing writer's data is dropped
    task automatic mem_wr();
        if (busy_force_i) return;
        if (!hb_n_i) mem[addr_i][DW-1:DW/2] = data_i[DW-1:DW/2];
        if (!lb_n_i) mem[addr_i][DW/2-1:0] = data_i[DW/2-1:0];
        if (addr_i == dprc_pkg::MBOX_RIGHT) peer_flag_o = 1'b1;
    endtask : mem_wr
    task automatic tok_wr();
        if (data_i[0]) own_r[addr_i[2:0]] = 1'b0;
        else if (!peer_hold_i[addr_i[2:0]]) own_r[addr_i[2:0]] = 1'b1;
    endtask : tok_wr
    // Data lands on the rising edge that ends the strobe
    always @(posedge wnr_i) if (!sel_n_i) mem_wr(); else if (!tok_n_i) tok_wr();
    always @(posedge sel_n_i) if (!wnr_i) mem_wr();
    always @(posedge tok_n_i) if (!wnr_i) tok_wr();
    // Settle delay avoids racing pins that change in one step
    always begin
        @(posedge peer_post_i or negedge oe_n_i);
        #1;
        if (!oe_n_i && !sel_n_i && wnr_i && addr_i == dprc_pkg::MBOX_LEFT) alert_r = 1'b0;
        else if (peer_post_i) alert_r = 1'b1;
    end
    // Undriven bus shows inverted data so stale values never pass
    always_comb begin
        rd_v   = tok_n_i ? mem[addr_i] : {DW{~own_r[addr_i[2:0]]}};
        drv    = !oe_n_i && wnr_i && (!sel_n_i || !tok_n_i);
        data_o = drv ? rd_v : ~rd_v;
    end
    always @(drv or data_oe_n_i) #1 if (drv && !data_oe_n_i) clash_o++;
endmodule : dprc_dev_model

// ### testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the port controller against a port model
module testbench;
    localparam int DW = dprc_pkg::DATA_W;
    typedef struct packed { logic rt; logic rd; logic [DW-1:0] d; } dprc_exp_t;
    logic          clk_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          req = 1'b0, wr = 1'b0, tok = 1'b0, esel = 1'b0, aw = 1'b0;
    logic [13:0]   addr = 14'h0000;
    logic [DW-1:0] wdata = '0;
    logic [1:0]    lanes = 2'h3;
    logic          busy_f = 1'b0, post = 1'b0;
    logic [7:0]    hold = 8'h00;
    logic          ack, retry, alert, sel_n, wnr, oe_n, tok_n, hb_n, lb_n, doe_n, busy_n, alert_n;
    logic          pflag;
    logic [13:0]   pa;
    logic [DW-1:0] rdata, dout, mdata, bus;
    int            clash, err_total = 0, cmp_count = 0, cyc = 0;
    logic [31:0]   seed = 32'h0000002F;
    logic [DW-1:0] shadow [0:16383];
    dprc_exp_t     expq [$];
    dprc_exp_t     me;
    // Controller wins the bus while its enable is low
    assign bus = doe_n ? mdata : dout;
    dprc_port_ctrl #(.DATA_W(DW)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .req_write_i(wr), .req_token_i(tok), .req_end_by_sel_i(esel), .req_after_write_i(aw),
        .req_addr_i(addr), .req_wdata_i(wdata), .req_lanes_i(lanes), .ack_o(ack),
        .retry_o(retry), .rdata_o(rdata), .alert_o(alert), .port_sel_n_o(sel_n),
        .write_not_read_o(wnr), .out_en_n_o(oe_n), .token_latch_select_n_o(tok_n),
        .high_byte_select_n_o(hb_n), .low_byte_select_n_o(lb_n), .addr_o(pa), .data_o(dout),
        .data_oe_n_o(doe_n), .data_i(bus), .busy_n_i(busy_n), .alert_n_i(alert_n));
    dprc_dev_model #(.DW(DW)) dev (.sel_n_i(sel_n), .wnr_i(wnr), .oe_n_i(oe_n), .tok_n_i(tok_n),
        .hb_n_i(hb_n), .lb_n_i(lb_n), .addr_i(pa), .data_i(bus), .data_oe_n_i(doe_n),
        .busy_force_i(busy_f), .peer_post_i(post), .peer_hold_i(hold), .data_o(mdata),
        .busy_n_o(busy_n), .alert_n_o(alert_n), .peer_flag_o(pflag), .clash_o(clash));
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // Request held until the answer, dropped on the answer cycle
    task automatic op(input logic w, t, s, a, input logic [13:0] ad, input logic [DW-1:0] d,
                      input logic [1:0] ln, input dprc_exp_t e);
        int n;
        expq.push_back(e);
        @(negedge clk_i);
        {req, wr, tok, esel, aw, addr, wdata, lanes} <= {1'b1, w, t, s, a, ad, d, ln};
        n = 0;
        do begin @(negedge clk_i); n++; end while (ack !== 1'b1 && retry !== 1'b1 && n < 40);
        req <= 1'b0;
    endtask : op
    task automatic wrm(input logic [13:0] ad, input logic [DW-1:0] d, input logic [1:0] ln,
                       input logic s);
        if (ln[1]) shadow[ad][DW-1:DW/2] = d[DW-1:DW/2];
        if (ln[0]) shadow[ad][DW/2-1:0] = d[DW/2-1:0];
        op(1'b1, 1'b0, s, 1'b0, ad, d, ln, '{1'b0, 1'b0, '0});
    endtask : wrm
    task automatic rdm(input logic [13:0] ad, input logic a);
        op(1'b0, 1'b0, 1'b0, a, ad, '0, 2'h3, '{1'b0, 1'b1, shadow[ad]});
    endtask : rdm
    // Oldest note is matched against each completion
    always @(negedge clk_i) if (ack === 1'b1 || retry === 1'b1) begin
        me = expq.pop_front();
        chk(DW'(retry), DW'(me.rt));
        if (me.rd && !me.rt) chk(rdata, me.d);
    end
    // Hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            $display("mismatch at %0t: run timed out", $time);
            end_of_test();
        end
    end
    initial begin
        logic [31:0] r;
        repeat (16) @(negedge clk_i);
        rst_n_i <= 1'b1;
        // Random words, edge addresses, both write endings
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            addr = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFD : r[13:0];
            wrm(addr, DW'(rnd()), 2'h3, i[0]);
            rdm(addr, i[1]);
        end
        $display("test words done");
        // Full-word then single-lane updates merge into the old word
        for (int k = 3; k > 0; k--) begin
            wrm(14'h0100, DW'(rnd()), k[1:0], 1'b0);
            rdm(14'h0100, 1'b0);
        end
        $display("test lanes done");
        // Busy port must retry and its write must not land
        busy_f = 1'b1;
        op(1'b1, 1'b0, 1'b0, 1'b0, 14'h0100, ~shadow[14'h0100], 2'h3, '{1'b1, 1'b0, '0});
        op(1'b0, 1'b0, 1'b0, 1'b0, 14'h0100, '0, 2'h3, '{1'b1, 1'b1, '0});
        busy_f = 1'b0;
        rdm(14'h0100, 1'b0);
        $display("test busy done");
        // Every latch claimed and released, one held by the peer
        hold = 8'h20;
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            op(1'b1, 1'b1, 1'b0, 1'b0, {r[13:3], k[2:0]}, '0, 2'h3, '{1'b0, 1'b0, '0});
            op(1'b0, 1'b1, 1'b0, 1'b0, {r[10:0], k[2:0]}, '0, 2'h3, '{1'b0, 1'b1, {DW{k == 5}}});
            op(1'b1, 1'b1, 1'b0, 1'b0, 14'(k), DW'(1), 2'h3, '{1'b0, 1'b0, '0});
            op(1'b0, 1'b1, 1'b0, 1'b0, 14'(k), '0, 2'h3, '{1'b0, 1'b1, {DW{1'b1}}});
        end
        $display("test tokens done");
        // Mailbox flags: peer post, foreign read, owner read
        wrm(dprc_pkg::MBOX_LEFT, DW'(rnd()), 2'h3, 1'b0);
        wrm(dprc_pkg::MBOX_RIGHT, DW'(rnd()), 2'h3, 1'b0);
        chk(DW'(pflag), DW'(1));
        @(negedge clk_i) post = 1'b1;
        @(negedge clk_i) post = 1'b0;
        repeat (2) @(negedge clk_i);
        chk(DW'(alert), DW'(1));
        rdm(dprc_pkg::MBOX_RIGHT, 1'b0);
        repeat (3) @(negedge clk_i);
        chk(DW'(alert), DW'(1));
        rdm(dprc_pkg::MBOX_LEFT, 1'b0);
        repeat (3) @(negedge clk_i);
        chk(DW'(alert), DW'(0));
        $display("test mailbox done");
        chk(DW'(clash), '0);
        chk(DW'(expq.size()), '0);
        end_of_test();
    end
endmodule : testbench
